// file: core/rap_pkg.sv
// constants and carrier types for the reactive and apparent power engine
package rap_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int SMP_W = 24;
    localparam int PWR_W = 29;
    localparam int NRG_W = 32;
    localparam int OFS_W = 10;
    localparam int NPWR  = 3;

    ////////////////////////////////////////////////////////////////////////
    // register word indices
    localparam logic [4:0] REG_CTRL1  = 5'h00;
    localparam logic [4:0] REG_CTRL2  = 5'h01;
    localparam logic [4:0] REG_OFFS1  = 5'h02;
    localparam logic [4:0] REG_OFFS2  = 5'h03;
    localparam logic [4:0] REG_STAT1  = 5'h04;
    localparam logic [4:0] REG_STAT2  = 5'h05;
    localparam logic [4:0] REG_EVNT1  = 5'h06;
    localparam logic [4:0] REG_EVNT2  = 5'h07;
    localparam logic [4:0] REG_MASK1  = 5'h08;
    localparam logic [4:0] REG_MASK2  = 5'h09;
    localparam logic [4:0] REG_CH1    = 5'h10;
    localparam logic [4:0] REG_CH2    = 5'h18;
    localparam logic [2:0] SUB_QNRG   = 3'h0;
    localparam logic [2:0] SUB_QAVG   = 3'h1;
    localparam logic [2:0] SUB_QMOM   = 3'h2;
    localparam logic [2:0] SUB_SNRG   = 3'h3;
    localparam logic [2:0] SUB_SRMS   = 3'h4;
    localparam logic [2:0] SUB_SVEC   = 3'h5;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_APM_BIT = 0;
    localparam int CTRL_AEM_BIT = 1;
    localparam int OFS_R_LSB    = 0;
    localparam int OFS_S_LSB    = 16;
    localparam int SGN_REACT    = 0;
    localparam int SGN_SRMS     = 1;
    localparam int SGN_SVEC     = 2;
    localparam int MUL_LSB      = 19;
    localparam int OFS_SHIFT    = 2;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [1:0]       CTRL_RST = 2'h0;
    localparam logic [OFS_W-1:0] OFS_RST  = 10'h000;
    localparam logic [NPWR-1:0]  BITS_RST = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS  = 4;
    localparam int LINE_PERIOD_NS = 20_000_000;
    localparam int SIGN_DELAY_NS  = LINE_PERIOD_NS / 2;
    localparam int SIGN_DELAY_CYC = SIGN_DELAY_NS / CLK_PERIOD_NS;
    localparam int LPF_SHIFT_DEF  = 8;

    ////////////////////////////////////////////////////////////////////////
    // one channel of filtered samples from the decimation stage
    typedef struct packed {
        logic signed [SMP_W-1:0] v_fund;
        logic signed [SMP_W-1:0] c_fund;
        logic signed [PWR_W-1:0] p_wide;
        logic signed [PWR_W-1:0] p_fund;
        logic        [SMP_W-1:0] v_rms;
        logic        [SMP_W-1:0] c_rms;
    } rap_chan_in_t;

endpackage : rap_pkg

// file: core/rap_sqrt.sv
// sequential integer square root, one result bit per clock
module rap_sqrt #(
    parameter int W = 29
) (
    input  wire logic           mclk,
    input  wire logic           rstn,
    input  wire logic           start,
    input  wire logic [2*W-1:0] radicand,
    output logic      [W-1:0]   root,
    output logic                done
);
    localparam int CW = $clog2(W + 1);

    typedef struct packed {
        logic           busy;
        logic           done;
        logic [CW-1:0]  cnt;
        logic [2*W-1:0] x;
        logic [W:0]     rem;
        logic [W-1:0]   root;
    } rap_sqrt_st_t;

    rap_sqrt_st_t s;
    rap_sqrt_st_t n;

    if (W < 2) begin : g_chk
        $error("rap_sqrt width too small");
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [W+2:0] rsh;
        logic [W+2:0] trial;
        rsh   = '0;
        trial = '0;
        n     = s;
        n.done = 1'b0;
        if (start) begin
            n.busy = 1'b1;
            n.x    = radicand;
            n.rem  = '0;
            n.root = '0;
            n.cnt  = CW'(W);
        end else if (s.busy) begin
            rsh   = {s.rem, s.x[2*W-1 -: 2]};
            trial = {1'b0, s.root, 2'b01};
            if (rsh >= trial) begin
                n.rem  = (W+1)'(rsh - trial);
                n.root = {s.root[W-2:0], 1'b1};
            end else begin
                n.rem  = rsh[W:0];
                n.root = {s.root[W-2:0], 1'b0};
            end
            n.x   = {s.x[2*W-3:0], 2'b00};
            n.cnt = s.cnt - CW'(1);
            if (s.cnt == CW'(1)) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign root = s.root;
    assign done = s.done;

endmodule : rap_sqrt

// file: core/rap_engine.sv
// reactive and apparent power engine with avalon register slave
// Overview of operation
// RL1: reactive power is delayed current times delayed voltage per channel
// RL2: signed 9-bit reactive offset is added before averaging
// RL3: low-pass filter gives averaged reactive power
// RL4: per channel 32-bit reactive energy, 29-bit averaged and momentary power
// RL5: vectorial apparent power is sqrt of active squared plus reactive squared
// RL6: per channel bit picks wideband or fundamental active power
// RL7: rms apparent power is voltage rms times current rms
// RL8: signed 9-bit apparent offset is added to rms apparent power
// RL9: per channel bit picks vectorial or rms power for apparent energy
// RL10: per channel 32-bit apparent energy, 29-bit rms and vectorial power
// RL11: one sign bit per power in status and in event registers
// RL12: sign bit is one for negative power, zero for positive
// RL13: sign bit changes only after half a line period
// RL14: energies accumulate once per decimated sample
// RL15: energies are signed up-down counters that wrap
// RL16: offset field is sign bit plus nine magnitude bits, reset zero
// RL17: reactive path delays fundamental voltage and current first
// RL18: both channels run independently with their own settings
// RL19: 29-bit powers are two's complement
module rap_engine
    import rap_pkg::*;
#(
    parameter int SIGN_DELAY = rap_pkg::SIGN_DELAY_CYC,
    parameter int LPF_SHIFT  = rap_pkg::LPF_SHIFT_DEF
) (
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    input  wire logic                      sample_valid,
    input  wire rap_pkg::rap_chan_in_t [1:0] chan_in,
    input  wire logic [4:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    output logic                           irq
);
    import rap_pkg::*;

    localparam int CW = $clog2(SIGN_DELAY + 1);

    if (SIGN_DELAY < 1 || LPF_SHIFT < 1 || LPF_SHIFT > 16) begin : g_chk
        $error("rap_engine parameter out of range");
    end

    typedef struct packed {
        logic                              wait_q;
        logic [31:0]                       rdata;
        logic                              irq;
        logic [1:0][1:0]                   ctrl;
        logic [1:0][OFS_W-1:0]             ofs_r;
        logic [1:0][OFS_W-1:0]             ofs_s;
        logic [1:0][NPWR-1:0]              mask;
        logic [1:0][NPWR-1:0]              evnt;
        logic [1:0][NPWR-1:0]              sign;
        logic [1:0][NPWR-1:0][CW-1:0]      cnt;
        logic [1:0][SMP_W-1:0]             v_d;
        logic [1:0][SMP_W-1:0]             c_d;
        logic [1:0][PWR_W-1:0]             psel;
        logic [1:0][PWR_W-1:0]             q_mom;
        logic [1:0][PWR_W-1:0]             q_avg;
        logic [1:0][PWR_W-1:0]             s_rms;
        logic [1:0][PWR_W-1:0]             s_vec;
        logic [1:0][NRG_W-1:0]             e_q;
        logic [1:0][NRG_W-1:0]             e_s;
        logic [1:0]                        sq_go;
    } rap_state_t;

    rap_state_t s;
    rap_state_t n;

    logic [1:0][2*PWR_W-1:0] rad;
    logic [1:0][PWR_W-1:0]   root;
    logic [1:0]              done;

    ////////////////////////////////////////////////////////////////////////
    // arithmetic helpers
    function automatic logic [PWR_W-1:0] rap_mul(
        input logic [SMP_W-1:0] a,
        input logic [SMP_W-1:0] b
    );
        logic signed [2*SMP_W-1:0] p;
        p = $signed(a) * $signed(b);
        return p[MUL_LSB +: PWR_W];
    endfunction : rap_mul

    function automatic logic [PWR_W-1:0] rap_ofs(
        input logic [PWR_W-1:0] x,
        input logic [OFS_W-1:0] f
    );
        logic [PWR_W-1:0] m;
        m = PWR_W'({f[OFS_W-2:0], 2'b00});
        return f[OFS_W-1] ? x - m : x + m; // RL16
    endfunction : rap_ofs

    function automatic logic [NRG_W-1:0] rap_sx(input logic [PWR_W-1:0] x);
        return {{(NRG_W-PWR_W){x[PWR_W-1]}}, x}; // RL19
    endfunction : rap_sx

    function automatic logic [2*PWR_W-1:0] rap_sq(
        input logic [PWR_W-1:0] x
    );
        logic signed [2*PWR_W-1:0] p;
        p = $signed(x) * $signed(x);
        return p;
    endfunction : rap_sq

    function automatic logic [PWR_W-1:0] rap_pos(input logic [PWR_W-1:0] r);
        return r[PWR_W-1] ? {1'b0, {(PWR_W-1){1'b1}}} : r;
    endfunction : rap_pos

    ////////////////////////////////////////////////////////////////////////
    // square root units, one per channel
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        assign rad[ch] = rap_sq(s.psel[ch]) + rap_sq(s.q_avg[ch]); // RL5
        rap_sqrt #(
            .W        (PWR_W)
        ) u_sqrt (
            .mclk     (mclk),
            .rstn     (rstn),
            .start    (s.sq_go[ch]),
            .radicand (rad[ch]),
            .root     (root[ch]),
            .done     (done[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [PWR_W:0]      dif;
        logic [PWR_W:0]      stp;
        logic [NPWR-1:0]     raw;
        logic [NPWR-1:0]     set;
        logic [NPWR-1:0]     clr;
        logic                wr;
        logic                ch;
        dif = '0;
        stp = '0;
        raw = '0;
        set = '0;
        clr = '0;
        ch  = avs_address[3];
        wr  = avs_write && !s.wait_q;
        n   = s;
        n.sq_go = 2'b00;

        // bus handshake: one wait cycle, answer in the next
        n.wait_q = 1'b1;
        if ((avs_read || avs_write) && s.wait_q) begin
            n.wait_q = 1'b0;
            n.rdata  = '0;
            if (avs_address[4]) begin
                unique case (avs_address[2:0])
                    SUB_QNRG: n.rdata = s.e_q[ch]; // RL4
                    SUB_QAVG: n.rdata = {3'h0, s.q_avg[ch]};
                    SUB_QMOM: n.rdata = {3'h0, s.q_mom[ch]};
                    SUB_SNRG: n.rdata = s.e_s[ch]; // RL10
                    SUB_SRMS: n.rdata = {3'h0, s.s_rms[ch]};
                    SUB_SVEC: n.rdata = {3'h0, s.s_vec[ch]};
                    default:  n.rdata = '0;
                endcase
            end else begin
                unique case (avs_address[3:0])
                    REG_CTRL1[3:0]: n.rdata = {30'h0, s.ctrl[0]};
                    REG_CTRL2[3:0]: n.rdata = {30'h0, s.ctrl[1]};
                    REG_OFFS1[3:0]: n.rdata = {6'h0, s.ofs_s[0],
                                               6'h0, s.ofs_r[0]};
                    REG_OFFS2[3:0]: n.rdata = {6'h0, s.ofs_s[1],
                                               6'h0, s.ofs_r[1]};
                    REG_STAT1[3:0]: n.rdata = {29'h0, s.sign[0]}; // RL11
                    REG_STAT2[3:0]: n.rdata = {29'h0, s.sign[1]};
                    REG_EVNT1[3:0]: n.rdata = {29'h0, s.evnt[0]};
                    REG_EVNT2[3:0]: n.rdata = {29'h0, s.evnt[1]};
                    REG_MASK1[3:0]: n.rdata = {29'h0, s.mask[0]};
                    REG_MASK2[3:0]: n.rdata = {29'h0, s.mask[1]};
                    default:        n.rdata = '0;
                endcase
            end
        end

        // register writes
        if (wr && !avs_address[4]) begin
            unique case (avs_address[3:0])
                REG_CTRL1[3:0]: n.ctrl[0] = avs_writedata[1:0];
                REG_CTRL2[3:0]: n.ctrl[1] = avs_writedata[1:0];
                REG_OFFS1[3:0]: begin
                    n.ofs_r[0] = avs_writedata[OFS_R_LSB +: OFS_W];
                    n.ofs_s[0] = avs_writedata[OFS_S_LSB +: OFS_W];
                end
                REG_OFFS2[3:0]: begin
                    n.ofs_r[1] = avs_writedata[OFS_R_LSB +: OFS_W];
                    n.ofs_s[1] = avs_writedata[OFS_S_LSB +: OFS_W];
                end
                REG_MASK1[3:0]: n.mask[0] = avs_writedata[NPWR-1:0];
                REG_MASK2[3:0]: n.mask[1] = avs_writedata[NPWR-1:0];
                default: ;
            endcase
        end

        // per channel datapath
        for (int c = 0; c < 2; c++) begin // RL18
            if (sample_valid) begin
                n.v_d[c]   = chan_in[c].v_fund; // RL17
                n.c_d[c]   = chan_in[c].c_fund;
                n.q_mom[c] = rap_ofs(rap_mul(s.v_d[c], s.c_d[c]),
                                     s.ofs_r[c]); // RL1 RL2
                dif = {s.q_mom[c][PWR_W-1], s.q_mom[c]}
                    - {s.q_avg[c][PWR_W-1], s.q_avg[c]};
                stp = (PWR_W+1)'($signed(dif) >>> LPF_SHIFT);
                n.q_avg[c] = s.q_avg[c] + stp[PWR_W-1:0]; // RL3
                n.s_rms[c] = rap_ofs(rap_mul(chan_in[c].v_rms,
                                             chan_in[c].c_rms),
                                     s.ofs_s[c]); // RL7 RL8
                n.psel[c]  = s.ctrl[c][CTRL_APM_BIT] ?
                             chan_in[c].p_fund : chan_in[c].p_wide; // RL6
                n.sq_go[c] = 1'b1;
                n.e_q[c]   = s.e_q[c] + rap_sx(s.q_avg[c]); // RL14 RL15
                n.e_s[c]   = s.e_s[c] + rap_sx(s.ctrl[c][CTRL_AEM_BIT] ?
                             s.s_rms[c] : s.s_vec[c]); // RL9
            end
            if (done[c]) begin
                n.s_vec[c] = rap_pos(root[c]);
            end

            // sign filters
            raw[SGN_REACT] = s.q_avg[c][PWR_W-1]; // RL12
            raw[SGN_SRMS]  = s.s_rms[c][PWR_W-1];
            raw[SGN_SVEC]  = s.s_vec[c][PWR_W-1];
            set = '0;
            for (int k = 0; k < NPWR; k++) begin
                if (raw[k] == s.sign[c][k]) begin
                    n.cnt[c][k] = '0;
                end else if (s.cnt[c][k] == CW'(SIGN_DELAY - 1)) begin
                    n.cnt[c][k]  = '0;
                    n.sign[c][k] = raw[k]; // RL13
                    set[k]       = 1'b1;
                end else begin
                    n.cnt[c][k] = s.cnt[c][k] + CW'(1);
                end
            end
            clr = '0;
            if (wr && avs_address == (c == 0 ? REG_EVNT1 : REG_EVNT2)) begin
                clr = avs_writedata[NPWR-1:0];
            end
            n.evnt[c] = (s.evnt[c] & ~clr) | set; // RL11
        end
        n.irq = |(n.evnt & n.mask);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s        <= '0;
            s.wait_q <= 1'b1;
            s.ctrl   <= {CTRL_RST, CTRL_RST};
            s.ofs_r  <= {OFS_RST, OFS_RST};
            s.ofs_s  <= {OFS_RST, OFS_RST};
            s.mask   <= {BITS_RST, BITS_RST};
        end else begin
            s <= n;
        end
    end

    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = s.wait_q;
    assign irq             = s.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_ask;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_answer: assert property (@(posedge mclk) disable iff (!rstn)
        s_ask |=> s_ans)
        else $error("bus answer not in one cycle");

    a_react_mom: assert property (@(posedge mclk) disable iff (!rstn) // RL1
        sample_valid |=> s.q_mom[0] == rap_ofs(rap_mul($past(s.v_d[0]),
            $past(s.c_d[0])), $past(s.ofs_r[0])))
        else $error("momentary reactive power wrong");

    a_react_delay: assert property (@(posedge mclk) disable iff (!rstn) // RL17
        sample_valid |=> s.v_d[1] == $past(chan_in[1].v_fund))
        else $error("reactive delay stage wrong");

    a_rms_app: assert property (@(posedge mclk) disable iff (!rstn) // RL8
        sample_valid |=> s.s_rms[1] == rap_ofs(rap_mul(
            $past(chan_in[1].v_rms), $past(chan_in[1].c_rms)),
            $past(s.ofs_s[1])))
        else $error("rms apparent power wrong");

    a_energy_step: assert property (@(posedge mclk) disable iff (!rstn) // RL15
        sample_valid |=> s.e_q[0] == $past(s.e_q[0])
            + rap_sx($past(s.q_avg[0])))
        else $error("reactive energy step wrong");

    a_energy_hold: assert property (@(posedge mclk) disable iff (!rstn) // RL14
        !sample_valid |=> $stable(s.e_q[1]) && $stable(s.e_s[1]))
        else $error("energy moved without a sample");

    a_app_src: assert property (@(posedge mclk) disable iff (!rstn) // RL9
        sample_valid |=> s.e_s[0] == $past(s.e_s[0]) + rap_sx(
            $past(s.ctrl[0][CTRL_AEM_BIT]) ? $past(s.s_rms[0])
                                           : $past(s.s_vec[0])))
        else $error("apparent energy source wrong");

    a_sign_delay: assert property (@(posedge mclk) disable iff (!rstn) // RL13
        $changed(s.sign[0][SGN_REACT]) |->
            $past(s.cnt[0][SGN_REACT]) == CW'(SIGN_DELAY - 1))
        else $error("sign changed before delay");

    a_sign_level: assert property (@(posedge mclk) disable iff (!rstn) // RL12
        $rose(s.sign[0][SGN_REACT]) |-> $past(s.q_avg[0][PWR_W-1]))
        else $error("sign set for positive power");

    a_sign_event: assert property (@(posedge mclk) disable iff (!rstn) // RL11
        $changed(s.sign[0]) |-> (s.evnt[0] & (s.sign[0] ^ $past(s.sign[0])))
            == (s.sign[0] ^ $past(s.sign[0])))
        else $error("sign change lost its event");

    a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
        ##1 irq == |(s.evnt & s.mask))
        else $error("interrupt level wrong");

    a_event_clear: assert property (@(posedge mclk) disable iff (!rstn) // RL11
        avs_write && !avs_waitrequest && avs_address == REG_EVNT1 |=>
            (s.evnt[0] & $past(avs_writedata[NPWR-1:0])
                & ~(s.sign[0] ^ $past(s.sign[0]))) == '0)
        else $error("event bit not cleared");

    a_src_select: assert property (@(posedge mclk) disable iff (!rstn) // RL6
        sample_valid |=> s.psel[1] == ($past(s.ctrl[1][CTRL_APM_BIT])
            ? $past(chan_in[1].p_fund) : $past(chan_in[1].p_wide)))
        else $error("active power source wrong");

    a_bus_idle: assert property (@(posedge mclk) disable iff (!rstn)
        !avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without a request");

endmodule : rap_engine

// file: tb/rap_upstream.sv
// model of the upstream filter stage feeding paced sample pulses
module rap_upstream (
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    input  wire logic                        fire,
    input  wire logic                        slow,
    input  wire rap_pkg::rap_chan_in_t [1:0] next_in,
    output logic                             sample_valid,
    output rap_pkg::rap_chan_in_t [1:0]      chan_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import rap_pkg::*;

    logic [3:0] cnt_q;
    logic       arm_q;

    ////////////////////////////////////////////////////////////////////////
    // one pulse per request, prompt or slow; data scrambled between pulses
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q        <= 4'h0;
            arm_q        <= 1'b0;
            sample_valid <= 1'b0;
            chan_in      <= '0;
        end else begin
            sample_valid <= 1'b0;
            chan_in      <= ~chan_in;
            if (fire) begin
                arm_q <= 1'b1;
                cnt_q <= slow ? 4'hF : 4'h1;
            end else if (arm_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (arm_q) begin
                arm_q        <= 1'b0;
                sample_valid <= 1'b1;
                chan_in      <= next_in;
            end
        end
    end
endmodule : rap_upstream

// file: tb/testbench.sv
// self-checking bench for the reactive and apparent power engine
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rap_pkg::*;

    logic                     mclk;
    logic                     rstn;
    logic                     fire;
    logic                     slow;
    logic                     sample_valid;
    rap_chan_in_t [1:0]       chan_in;
    rap_chan_in_t [1:0]       next_in;
    logic [4:0]               avs_address;
    logic                     avs_read;
    logic                     avs_write;
    logic [31:0]              avs_writedata;
    logic [31:0]              avs_readdata;
    logic                     avs_waitrequest;
    logic                     irq;
    int                       err_total;
    int                       total_checks;
    logic [31:0]              q;
    logic signed [23:0]       vd;
    logic signed [23:0]       cd;
    logic signed [47:0]       pr;
    logic signed [28:0]       mom;
    logic signed [28:0]       avg;
    logic signed [28:0]       srm;
    logic signed [28:0]       sv1;
    logic [31:0]              eq;
    logic [31:0]              es;
    logic [31:0]              es1;
    logic                     apm1;

    always #2 mclk = ~mclk;

    rap_upstream UP (.mclk(mclk), .rstn(rstn), .fire(fire), .slow(slow),
        .next_in(next_in), .sample_valid(sample_valid), .chan_in(chan_in));

    rap_engine #(.SIGN_DELAY(8), .LPF_SHIFT(2)) DUT (.mclk(mclk),
        .rstn(rstn), .sample_valid(sample_valid), .chan_in(chan_in),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // compare, close, bus and stream tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_total++;
            stop_test();
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rc

    task automatic send();
        int n;
        n = 0;
        @(posedge mclk);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        while (sample_valid !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 40) begin
            err_total++;
            stop_test();
        end
        pr  = vd * cd;
        eq  = eq + 32'(avg);
        es  = es + 32'(srm);
        es1 = es1 + 32'(sv1);
        avg = avg + ((mom - avg) >>> 2);
        mom = pr[47:19] + 29'sd20;
        vd  = next_in[0].v_fund;
        cd  = next_in[0].c_fund;
        srm = -29'sd12;
        sv1 = apm1 ? 29'sd3000 : 29'sd1000;
    endtask : send

    task automatic check_all();
        rc(REG_CH1, eq);
        rc(REG_CH1 + 5'h1, {3'h0, avg});
        rc(REG_CH1 + 5'h2, {3'h0, mom});
        rc(REG_CH1 + 5'h3, es);
        rc(REG_CH1 + 5'h4, {3'h0, srm});
        rc(REG_CH2 + 5'h2, 32'h0);
        rc(REG_CH2 + 5'h3, es1);
        rc(REG_CH2 + 5'h4, 32'h0010_0000);
        rc(REG_CH2 + 5'h5, {3'h0, sv1});
    endtask : check_all

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        fire = 1'b0;
        slow = 1'b0;
        next_in = '0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        err_total = 0;
        total_checks = 0;
        {vd, cd, mom, avg, srm, sv1, eq, es, es1, apm1} = '0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            rc(5'(i), 32'h0);
        end
        bus(1'b1, REG_CTRL1, 32'hFFFF_FFFF);
        rc(REG_CTRL1, 32'h3);
        bus(1'b1, REG_OFFS1, 32'hFFFF_FFFF);
        rc(REG_OFFS1, 32'h03FF_03FF);
        bus(1'b1, REG_STAT1, 32'hFFFF_FFFF);
        bus(1'b1, 5'h0A, 32'hFFFF_FFFF);
        rc(REG_STAT1, 32'h0);
        rc(5'h0A, 32'h0);
        bus(1'b1, REG_CTRL1, 32'h2);
        bus(1'b1, REG_OFFS1, 32'h0203_0005);
        next_in[0].v_fund <= 24'hF0_0000;
        next_in[0].c_fund <= 24'h08_0000;
        next_in[1].v_fund <= 24'h10_0000;
        next_in[1].v_rms  <= 24'h10_0000;
        next_in[1].c_rms  <= 24'h08_0000;
        next_in[1].p_wide <= 29'd1000;
        next_in[1].p_fund <= 29'd3000;
        for (int k = 0; k < 4; k++) begin
            slow <= k[0];
            send();
            if (k == 0) begin
                rc(REG_STAT1, 32'h0);
            end
            repeat (40) @(posedge mclk);
            check_all();
        end
        rc(REG_STAT1, 32'h3);
        rc(REG_EVNT1, 32'h3);
        rc(REG_STAT2, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, REG_MASK1, 32'h2);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, REG_EVNT1, 32'h2);
        rc(REG_EVNT1, 32'h1);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, REG_CTRL2, 32'h1);
        apm1 = 1'b1;
        send();
        repeat (40) @(posedge mclk);
        check_all();
        stop_test();
    end
endmodule : testbench
